// File: rtl/adc_diag_pkg.sv
// ======================================================================
// shared constants and carriers
package adc_diag_pkg;

   // ===================================================================
   // bus geometry
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int IDX_W = 10;

   // ===================================================================
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_SEQ_CFG = 8'h10;
   localparam logic [7:0] IDX_SCAN_MASK = 8'h12;
   localparam logic [7:0] IDX_STATUS = 8'h20;
   localparam logic [7:0] IDX_KEY = 8'hbf;
   localparam logic [7:0] IDX_DIAGNOSTICS_ACTIVE = 8'hc0;
   localparam logic [7:0] IDX_PAT_LO = 8'hc1;
   localparam logic [7:0] IDX_PAT_HI = 8'hc2;

   // ===================================================================
   // values, masks and field positions
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] UNLOCK_KEY = 8'h96;
   localparam logic [7:0] DIAGNOSTICS_ACTIVE_WMASK = 8'h11;
   localparam logic [7:0] SEQ_CFG_WMASK = 8'h13;
   localparam logic [15:0] PATTERN_OFF = 16'h0000;
   localparam int WALK_BIT = 0;
   localparam int INJECT_BIT = 4;
   localparam int SEQUENCE_START_BIT_BIT = 4;
   localparam int SEQUENCING_MODE_SELECT_LSB = 0;
   localparam int STAT_UNLOCK_BIT = 7;
   localparam int STAT_ACTIVE_BIT = 3;

   // ===================================================================
   // channels
   localparam int N_CH = 8;
   localparam int CH_W = 3;

   typedef enum logic [1:0] {
      SEQ_MANUAL = 2'b00,
      SEQ_AUTO = 2'b01,
      SEQ_ON_THE_FLY = 2'b10,
      SEQ_RESERVED = 2'b11
   } sequencing_mode_select_t;

   typedef enum logic {
      SCAN_IDLE = 1'b0,
      SCAN_RUN = 1'b1
   } scan_state_t;

   typedef struct packed {
      logic walk;
      logic inject;
      logic active;
      logic [15:0] pattern;
   } diag_out_t;

   typedef struct packed {
      logic active;
      logic [CH_W-1:0] channel;
   } scan_out_t;

endpackage : adc_diag_pkg

// File: rtl/scan_sequencer.sv
// ======================================================================
// auto-scan channel stepper
module scan_sequencer (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic [adc_diag_pkg::N_CH-1:0] mask,
   input wire adc_diag_pkg::sequencing_mode_select_t mode,
   input wire logic start,
   input wire logic conv_done,
   output adc_diag_pkg::scan_out_t scan
);

   adc_diag_pkg::scan_state_t state;
   adc_diag_pkg::scan_state_t next_state;
   logic [adc_diag_pkg::CH_W-1:0] channel;
   logic [adc_diag_pkg::CH_W-1:0] next_channel;
   logic run_ok;
   logic [adc_diag_pkg::N_CH-1:0] prev_mask;

   // lowest enabled channel above cur, wrapping round
   function automatic logic [adc_diag_pkg::CH_W-1:0] pick_after(
      input logic [adc_diag_pkg::N_CH-1:0] m,
      input logic [adc_diag_pkg::CH_W-1:0] cur);
      logic [adc_diag_pkg::CH_W-1:0] sel;
      logic [adc_diag_pkg::CH_W-1:0] idx;
      logic found;
      sel = cur;
      found = 1'b0;
      for (int i = 1; i <= adc_diag_pkg::N_CH; i++) begin
         idx = adc_diag_pkg::CH_W'((int'(cur) + i) % adc_diag_pkg::N_CH);
         if (!found && m[idx]) begin
            sel = idx;
            found = 1'b1;
         end
      end
      return sel;
   endfunction

   // ===================================================================
   // stepping
   always_comb begin
      run_ok = start && (mode == adc_diag_pkg::SEQ_AUTO) && (|mask);
      next_state = state;
      next_channel = channel;
      case (state)
         adc_diag_pkg::SCAN_IDLE: begin
            if (run_ok) begin
               next_state = adc_diag_pkg::SCAN_RUN;
               next_channel = pick_after(mask,
                  adc_diag_pkg::CH_W'(adc_diag_pkg::N_CH - 1));
            end
         end
         default: begin
            if (!run_ok) begin
               next_state = adc_diag_pkg::SCAN_IDLE;
            end else if (conv_done || !mask[channel]) begin
               // a channel dropped from the mask is left at once
               next_channel = pick_after(mask, channel);
            end
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= adc_diag_pkg::SCAN_IDLE;
         channel <= '0;
         prev_mask <= '0;
      end else begin
         state <= next_state;
         channel <= next_channel;
         prev_mask <= mask;
      end
   end

   assign scan.active = (state == adc_diag_pkg::SCAN_RUN);
   assign scan.channel = channel;

   // ===================================================================
   // checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   a_mode_gate: assert property (
      mode != adc_diag_pkg::SEQ_AUTO |=> !scan.active)
      else $error("scan ran outside auto mode");

   a_stop_scan: assert property (
      !start |=> !scan.active)
      else $error("scan did not stop on cleared start");

   a_mask_member: assert property (
      scan.active |-> prev_mask[scan.channel])
      else $error("scan picked a masked channel");

endmodule // scan_sequencer

// File: rtl/adc_scan_select_diag_regs.sv
// ======================================================================
// Overview of operation
// - each mask bit includes one input
// - diagnostics writes need key 0x96 first
// - inject bit routes test voltage to input six
// - walk mode overrides test voltage injection
// - bit 0 selects bit walk mode
// - low pattern drives bit positions 7..0
// - high pattern drives bit positions 15..8
// - patterns inert while diagnostics inactive
// - mask used only in auto mode
// - start scans ascending; clear stops
module adc_scan_select_diag_regs (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [adc_diag_pkg::ADDR_W-1:0] paddr,
   input wire logic [adc_diag_pkg::DATA_W-1:0] pwdata,
   output logic [adc_diag_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic conv_done,
   output adc_diag_pkg::diag_out_t diag,
   output adc_diag_pkg::scan_out_t scan
);

   logic [7:0] seq_cfg;
   logic [7:0] scan_mask;
   logic [7:0] key;
   logic [7:0] diagnostics_active;
   logic [7:0] pat_lo;
   logic [7:0] pat_hi;
   logic [7:0] next_seq_cfg;
   logic [7:0] next_scan_mask;
   logic [7:0] next_key;
   logic [7:0] next_diagnostics_active;
   logic [7:0] next_pat_lo;
   logic [7:0] next_pat_hi;

   logic [adc_diag_pkg::DATA_W-1:0] next_prdata;
   logic next_pready;
   logic next_pslverr;
   adc_diag_pkg::diag_out_t next_diag;

   logic [adc_diag_pkg::IDX_W-1:0] word;
   logic aligned;
   logic access;
   logic wr_fire;
   logic unlocked;
   logic mapped;
   logic read_only;
   logic is_diag;
   logic [7:0] wbyte;
   logic [7:0] rd_val;
   logic [7:0] status;

   // ===================================================================
   // address decode
   assign word = paddr[adc_diag_pkg::ADDR_W-1:2];
   assign aligned = (paddr[1:0] == 2'b00);
   assign wbyte = pwdata[7:0];
   // request seen in its first access cycle; answered one edge later
   assign access = psel && penable && !pready;
   // writes land on the edge that samples pready high
   assign wr_fire = psel && penable && pready && pwrite;
   assign unlocked = (key == adc_diag_pkg::UNLOCK_KEY);

   always_comb begin
      mapped = 1'b1;
      read_only = 1'b0;
      is_diag = 1'b0;
      rd_val = 8'h00;
      if (!aligned) begin
         mapped = 1'b0;
      end else if (word == {2'b00, adc_diag_pkg::IDX_SEQ_CFG}) begin
         rd_val = seq_cfg;
      end else if (word == {2'b00, adc_diag_pkg::IDX_SCAN_MASK}) begin
         rd_val = scan_mask;
      end else if (word == {2'b00, adc_diag_pkg::IDX_STATUS}) begin
         rd_val = status;
         read_only = 1'b1;
      end else if (word == {2'b00, adc_diag_pkg::IDX_KEY}) begin
         rd_val = key;
      end else if (word == {2'b00, adc_diag_pkg::IDX_DIAGNOSTICS_ACTIVE}) begin
         rd_val = diagnostics_active;
         is_diag = 1'b1;
      end else if (word == {2'b00, adc_diag_pkg::IDX_PAT_LO}) begin
         rd_val = pat_lo;
         is_diag = 1'b1;
      end else if (word == {2'b00, adc_diag_pkg::IDX_PAT_HI}) begin
         rd_val = pat_hi;
         is_diag = 1'b1;
      end else begin
         mapped = 1'b0;
      end
   end

   always_comb begin
      status = 8'h00;
      status[adc_diag_pkg::STAT_UNLOCK_BIT] = unlocked;
      status[adc_diag_pkg::STAT_ACTIVE_BIT] = scan.active;
      status[adc_diag_pkg::CH_W-1:0] = scan.channel;
   end

   // ===================================================================
   // bus answer
   always_comb begin
      next_pready = access;
      next_pslverr = 1'b0;
      next_prdata = 32'h0000_0000;
      if (access) begin
         next_pslverr = !mapped || (pwrite && read_only);
         if (!pwrite && mapped) begin
            next_prdata = {24'h00_0000, rd_val};
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= next_pready;
         pslverr <= next_pslverr;
         prdata <= next_prdata;
      end
   end

   // ===================================================================
   // register file
   always_comb begin
      next_seq_cfg = seq_cfg;
      next_scan_mask = scan_mask;
      next_key = key;
      next_diagnostics_active = diagnostics_active;
      next_pat_lo = pat_lo;
      next_pat_hi = pat_hi;
      if (wr_fire && aligned) begin
         if (word == {2'b00, adc_diag_pkg::IDX_SEQ_CFG}) begin
            next_seq_cfg = wbyte & adc_diag_pkg::SEQ_CFG_WMASK;
         end
         if (word == {2'b00, adc_diag_pkg::IDX_SCAN_MASK}) begin
            next_scan_mask = wbyte;
         end
         if (word == {2'b00, adc_diag_pkg::IDX_KEY}) begin
            next_key = wbyte;
         end
         // locked: the write completes on the bus but stores nothing
         if (unlocked) begin
            if (word == {2'b00, adc_diag_pkg::IDX_DIAGNOSTICS_ACTIVE}) begin
               next_diagnostics_active = wbyte & adc_diag_pkg::DIAGNOSTICS_ACTIVE_WMASK;
            end
            if (word == {2'b00, adc_diag_pkg::IDX_PAT_LO}) begin
               next_pat_lo = wbyte;
            end
            if (word == {2'b00, adc_diag_pkg::IDX_PAT_HI}) begin
               next_pat_hi = wbyte;
            end
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         seq_cfg <= adc_diag_pkg::REG_RESET;
         scan_mask <= adc_diag_pkg::REG_RESET;
         key <= adc_diag_pkg::REG_RESET;
         diagnostics_active <= adc_diag_pkg::REG_RESET;
         pat_lo <= adc_diag_pkg::REG_RESET;
         pat_hi <= adc_diag_pkg::REG_RESET;
      end else begin
         seq_cfg <= next_seq_cfg;
         scan_mask <= next_scan_mask;
         key <= next_key;
         diagnostics_active <= next_diagnostics_active;
         pat_lo <= next_pat_lo;
         pat_hi <= next_pat_hi;
      end
   end

   // ===================================================================
   // diagnostics controls toward the converter
   always_comb begin
      next_diag.walk = diagnostics_active[adc_diag_pkg::WALK_BIT];
      // walk mode wins, so injection never disturbs a bit walk
      next_diag.inject = diagnostics_active[adc_diag_pkg::INJECT_BIT]
         && !diagnostics_active[adc_diag_pkg::WALK_BIT];
      next_diag.active = diagnostics_active[adc_diag_pkg::WALK_BIT]
         || diagnostics_active[adc_diag_pkg::INJECT_BIT];
      next_diag.pattern = adc_diag_pkg::PATTERN_OFF;
      if (next_diag.active) begin
         next_diag.pattern = {pat_hi, pat_lo};
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         diag <= '0;
      end else begin
         diag <= next_diag;
      end
   end

   // ===================================================================
   // channel stepping
   scan_sequencer u_seq (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .mask(scan_mask),
      .mode(adc_diag_pkg::sequencing_mode_select_t'(
         seq_cfg[adc_diag_pkg::SEQUENCING_MODE_SELECT_LSB +: 2])),
      .start(seq_cfg[adc_diag_pkg::SEQUENCE_START_BIT_BIT]),
      .conv_done(conv_done),
      .scan(scan)
   );

   // ===================================================================
   // checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   sequence s_access;
      psel && penable && !pready;
   endsequence

   sequence s_answer;
      pready ##1 !pready;
   endsequence

   a_bus_answer: assert property (
      s_access |=> s_answer)
      else $error("apb answer not one cycle after access");

   a_mask_store: assert property (
      wr_fire && aligned && word == {2'b00, adc_diag_pkg::IDX_SCAN_MASK}
      |=> scan_mask == $past(wbyte))
      else $error("scan mask write lost");

   a_unlock_write: assert property (
      wr_fire && aligned && unlocked
      && word == {2'b00, adc_diag_pkg::IDX_DIAGNOSTICS_ACTIVE}
      |=> diagnostics_active == ($past(wbyte) & adc_diag_pkg::DIAGNOSTICS_ACTIVE_WMASK))
      else $error("unlocked diagnostics write lost");

   a_locked_ignore: assert property (
      wr_fire && is_diag && !unlocked
      |=> $stable(diagnostics_active) && $stable(pat_lo) && $stable(pat_hi))
      else $error("locked diagnostics write took effect");

   a_inject_route: assert property (
      diagnostics_active[adc_diag_pkg::INJECT_BIT] && !diagnostics_active[adc_diag_pkg::WALK_BIT]
      |=> diag.inject)
      else $error("test voltage not routed");

   a_walk_wins: assert property (
      diagnostics_active[adc_diag_pkg::WALK_BIT] |=> diag.walk && !diag.inject)
      else $error("injection active during bit walk");

   a_walk_clear: assert property (
      !diagnostics_active[adc_diag_pkg::WALK_BIT] |=> !diag.walk)
      else $error("bit walk left on");

   a_pattern_low: assert property (
      diag.active |-> diag.pattern[7:0] == $past(pat_lo))
      else $error("low pattern mismatch");

   a_pattern_high: assert property (
      diag.active |-> diag.pattern[15:8] == $past(pat_hi))
      else $error("high pattern mismatch");

   a_pattern_gated: assert property (
      !diag.active |-> diag.pattern == adc_diag_pkg::PATTERN_OFF)
      else $error("pattern applied while inactive");

   a_active_gate: assert property (
      !diagnostics_active[adc_diag_pkg::WALK_BIT] && !diagnostics_active[adc_diag_pkg::INJECT_BIT]
      |=> !diag.active)
      else $error("diagnostics active with both enables clear");

   a_inject_off: assert property (
      !diagnostics_active[adc_diag_pkg::INJECT_BIT] |=> !diag.inject)
      else $error("test voltage routed while disabled");

   a_key_store: assert property (
      wr_fire && aligned && word == {2'b00, adc_diag_pkg::IDX_KEY}
      |=> key == $past(wbyte))
      else $error("key write lost");

   a_pat_lo_store: assert property (
      wr_fire && aligned && unlocked
      && word == {2'b00, adc_diag_pkg::IDX_PAT_LO}
      |=> pat_lo == $past(wbyte))
      else $error("low pattern write lost");

   a_pat_hi_store: assert property (
      wr_fire && aligned && unlocked
      && word == {2'b00, adc_diag_pkg::IDX_PAT_HI}
      |=> pat_hi == $past(wbyte))
      else $error("high pattern write lost");

   // a refused access must still complete, only flagged
   a_error_flag: assert property (
      s_access && (!mapped || (pwrite && read_only)) |=> pslverr)
      else $error("refused access not flagged");

   a_read_upper: assert property (
      pready |-> prdata[31:8] == 24'h00_0000)
      else $error("read data upper lanes not zero");

endmodule // adc_scan_select_diag_regs

// File: sim/adc_scan_select_diag_regs_test.sv
// ======================================================================
// register bench for the scan mask and the keyed diagnostics group
module adc_scan_select_diag_regs_test;
   timeunit 1ns;
   timeprecision 1ns;

   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic conv_done = 1'b0;
   adc_diag_pkg::diag_out_t diag;
   adc_diag_pkg::scan_out_t scan;
   int errors = 0;
   int compares = 0;
   int cycles = 0;
   logic [31:0] r;
   logic e;

   always #50 ref_clk = ~ref_clk;

   adc_scan_select_diag_regs u_dut (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .conv_done(conv_done),
      .diag(diag),
      .scan(scan)
   );

   // ===================================================================
   // helpers
   function automatic logic [11:0] addr_of(input logic [7:0] idx);
      return {2'b00, idx, 2'b00};
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // outputs are flops, so the values read at the edge are pre-edge ones
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] rv,
                      output logic ev);
      int n;
      n = 0;
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         errors++;
         $display("Error at %0t: no bus answer", $time);
      end
      rv = prdata;
      ev = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      apb(1'b1, addr_of(idx), {24'h00_0000, d}, r, e);
   endtask

   task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
      apb(1'b0, addr_of(idx), 32'h0000_0000, r, e);
      chk(r, {24'h00_0000, exp});
   endtask

   task automatic settle;
      repeat (3) @(posedge ref_clk);
   endtask

   task automatic dchk(input logic [18:0] exp);
      settle();
      chk({13'h0000, diag}, {13'h0000, exp});
   endtask

   task automatic schk(input logic act, input logic [2:0] ch);
      settle();
      chk({28'h000_0000, scan}, {28'h000_0000, act, ch});
   endtask

   task automatic conv;
      @(posedge ref_clk);
      conv_done <= 1'b1;
      @(posedge ref_clk);
      conv_done <= 1'b0;
   endtask

   // ===================================================================
   // scenarios
   task automatic t_reset;
      rdc(adc_diag_pkg::IDX_SCAN_MASK, 8'h00);
      rdc(adc_diag_pkg::IDX_KEY, 8'h00);
      rdc(adc_diag_pkg::IDX_DIAGNOSTICS_ACTIVE, 8'h00);
      rdc(adc_diag_pkg::IDX_PAT_LO, 8'h00);
      rdc(adc_diag_pkg::IDX_PAT_HI, 8'h00);
      dchk(19'h0_0000);
   endtask

   task automatic t_locked;
      wr(adc_diag_pkg::IDX_DIAGNOSTICS_ACTIVE, 8'h11);
      wr(adc_diag_pkg::IDX_PAT_LO, 8'ha5);
      wr(adc_diag_pkg::IDX_KEY, 8'h95);
      wr(adc_diag_pkg::IDX_PAT_HI, 8'h5a);
      rdc(adc_diag_pkg::IDX_DIAGNOSTICS_ACTIVE, 8'h00);
      rdc(adc_diag_pkg::IDX_PAT_LO, 8'h00);
      rdc(adc_diag_pkg::IDX_PAT_HI, 8'h00);
      dchk(19'h0_0000);
   endtask

   task automatic t_diag;
      wr(adc_diag_pkg::IDX_KEY, 8'h96);
      rdc(adc_diag_pkg::IDX_KEY, 8'h96);
      rdc(adc_diag_pkg::IDX_STATUS, 8'h80);
      wr(adc_diag_pkg::IDX_PAT_LO, 8'h5a);
      wr(adc_diag_pkg::IDX_PAT_HI, 8'hc3);
      rdc(adc_diag_pkg::IDX_PAT_LO, 8'h5a);
      rdc(adc_diag_pkg::IDX_PAT_HI, 8'hc3);
      dchk(19'h0_0000);
      wr(adc_diag_pkg::IDX_DIAGNOSTICS_ACTIVE, 8'hff);
      rdc(adc_diag_pkg::IDX_DIAGNOSTICS_ACTIVE, 8'h11);
      dchk({1'b1, 1'b0, 1'b1, 16'hc35a});
      wr(adc_diag_pkg::IDX_DIAGNOSTICS_ACTIVE, 8'h01);
      dchk({1'b1, 1'b0, 1'b1, 16'hc35a});
      wr(adc_diag_pkg::IDX_DIAGNOSTICS_ACTIVE, 8'h10);
      dchk({1'b0, 1'b1, 1'b1, 16'hc35a});
      wr(adc_diag_pkg::IDX_DIAGNOSTICS_ACTIVE, 8'h00);
      dchk(19'h0_0000);
      // a wrong key relocks the group
      wr(adc_diag_pkg::IDX_KEY, 8'h00);
      wr(adc_diag_pkg::IDX_DIAGNOSTICS_ACTIVE, 8'h10);
      rdc(adc_diag_pkg::IDX_DIAGNOSTICS_ACTIVE, 8'h00);
      dchk(19'h0_0000);
   endtask

   task automatic t_scan;
      wr(adc_diag_pkg::IDX_SCAN_MASK, 8'h8a);
      rdc(adc_diag_pkg::IDX_SCAN_MASK, 8'h8a);
      wr(adc_diag_pkg::IDX_SEQ_CFG, 8'h01);
      schk(1'b0, 3'h0);
      wr(adc_diag_pkg::IDX_SEQ_CFG, 8'h11);
      schk(1'b1, 3'h1);
      rdc(adc_diag_pkg::IDX_STATUS, 8'h09);
      conv();
      schk(1'b1, 3'h3);
      conv();
      schk(1'b1, 3'h7);
      conv();
      schk(1'b1, 3'h1);
      // a stopped scan keeps showing the last channel it visited
      wr(adc_diag_pkg::IDX_SEQ_CFG, 8'h10);
      schk(1'b0, 3'h1);
      wr(adc_diag_pkg::IDX_SEQ_CFG, 8'h12);
      schk(1'b0, 3'h1);
      wr(adc_diag_pkg::IDX_SEQ_CFG, 8'h13);
      schk(1'b0, 3'h1);
      wr(adc_diag_pkg::IDX_SEQ_CFG, 8'h11);
      schk(1'b1, 3'h1);
      wr(adc_diag_pkg::IDX_SEQ_CFG, 8'h01);
      schk(1'b0, 3'h1);
   endtask

   // refused accesses must not disturb the mask
   task automatic t_refused;
      apb(1'b0, 12'h049, 32'h0000_0000, r, e);
      chk({31'h0000_0000, e}, 32'h0000_0001);
      apb(1'b1, 12'h0fc, 32'h0000_0055, r, e);
      chk({31'h0000_0000, e}, 32'h0000_0001);
      apb(1'b1, addr_of(adc_diag_pkg::IDX_STATUS), 32'h0000_00ff, r, e);
      chk({31'h0000_0000, e}, 32'h0000_0001);
      apb(1'b1, 12'h04a, 32'h0000_0055, r, e);
      chk({31'h0000_0000, e}, 32'h0000_0001);
      apb(1'b0, addr_of(adc_diag_pkg::IDX_SCAN_MASK), 32'h0000_0000, r, e);
      chk({31'h0000_0000, e}, 32'h0000_0000);
      chk(r, 32'h0000_008a);
      rdc(adc_diag_pkg::IDX_SCAN_MASK, 8'h8a);
   endtask

   // ===================================================================
   // verdict and run control
   task automatic summarize;
      if (errors == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         errors++;
         summarize();
      end
   end

   initial begin
      repeat (3) @(posedge ref_clk);
      rst_b <= 1'b1;
      t_reset();
      t_locked();
      t_diag();
      t_scan();
      t_refused();
      summarize();
   end
endmodule // adc_scan_select_diag_regs_test
